// [design/fpec_ctrl.sv]
// Purpose: Flash program/erase command register with erase timers, row
//          programming column tracking and flash access hold outputs.
// Assumes: Requests are synchronous to aclk; row_byte_wr pulses once per
//          byte written during row programming.
// Notes:   Behaviour
// Behaviour
// - Command register eight bits, top five zero
// - Bit two enables row programming
// - Row bit clears at column 128 or timeout
// - Bit one erases page, self-clears
// - Bit zero erases whole array, self-clears
// - Full erase 200 ms, page 10 ms
// - Erase holds all flash reads and writes
// - Row programming holds flash reads
`timescale 1ns/1ps
`default_nettype none
module fpec_ctrl #(
    parameter int unsigned MASS_CYCLES = fpec_pkg::MASS_CYC,
    parameter int unsigned PAGE_CYCLES = fpec_pkg::PAGE_CYC,
    parameter int unsigned ROW_TMO_CYCLES = fpec_pkg::ROW_TMO_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [fpec_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [fpec_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Selects from page and column registers
    input wire logic [6:0] page_select,
    input wire logic info_area_select,
    input wire logic [6:0] col_start,
    // Row programming byte strobe
    input wire logic row_byte_wr,
    // Flash engine controls
    output logic mass_erase_on,
    output logic page_wipe_on,
    output logic row_write_on,
    output logic [6:0] erase_page,
    output logic erase_info,
    output logic [6:0] row_col,
    // Processor flash access holds
    output logic flash_rd_hold,
    output logic flash_wr_hold
);
    fpec_pkg::fpec_regs_t r_ff;
    fpec_pkg::fpec_regs_t nxt_r;

    always_comb begin
        logic wr_fire;
        logic [7:0] cmd;
        logic [7:0] col_inc;
        wr_fire = r_ff.aw_got && r_ff.w_got && !r_ff.bvalid;
        cmd = r_ff.wdata[7:0];
        col_inc = 8'(r_ff.col + 8'h01);
        nxt_r = r_ff;

        // Write channels are taken independently
        if (r_ff.awready && awvalid) begin
            nxt_r.awready = 1'b0;
            nxt_r.aw_got = 1'b1;
            nxt_r.awaddr = awaddr;
        end
        if (r_ff.wready && wvalid) begin
            nxt_r.wready = 1'b0;
            nxt_r.w_got = 1'b1;
            nxt_r.wdata = wdata;
            nxt_r.wstrb = wstrb;
        end
        if (wr_fire) begin
            nxt_r.aw_got = 1'b0;
            nxt_r.w_got = 1'b0;
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp = fpec_pkg::RESP_OKAY;
            if (r_ff.awaddr != fpec_pkg::CMD_ADDR &&
                r_ff.awaddr != fpec_pkg::STAT_ADDR) begin
                nxt_r.bresp = fpec_pkg::RESP_SLVERR;
            end
            // Write one clears; a same-cycle set below wins
            if (r_ff.awaddr == fpec_pkg::STAT_ADDR && r_ff.wstrb[0]) begin
                if (r_ff.wdata[fpec_pkg::TMO_BIT]) begin
                    nxt_r.tmo = 1'b0;
                end
                if (r_ff.wdata[fpec_pkg::DONE_BIT]) begin
                    nxt_r.done = 1'b0;
                end
            end
        end
        if (r_ff.bvalid && bready) begin
            nxt_r.bvalid = 1'b0;
            nxt_r.awready = 1'b1;
            nxt_r.wready = 1'b1;
        end

        // Operation timers and row column tracking
        case (r_ff.st)
            fpec_pkg::ST_IDLE: begin
            end
            fpec_pkg::ST_MASS, fpec_pkg::ST_PAGE: begin
                if (r_ff.cnt == '0) begin
                    nxt_r.st = fpec_pkg::ST_IDLE;
                    nxt_r.done = 1'b1;
                end else begin
                    nxt_r.cnt = fpec_pkg::fpec_cnt_t'(r_ff.cnt - 1'b1);
                end
            end
            fpec_pkg::ST_ROW: begin
                if (row_byte_wr) begin
                    nxt_r.col = col_inc;
                end
                if (row_byte_wr && col_inc == fpec_pkg::COL_END) begin
                    nxt_r.st = fpec_pkg::ST_IDLE;
                    nxt_r.done = 1'b1;
                end else if (r_ff.cnt == '0) begin
                    nxt_r.st = fpec_pkg::ST_IDLE;
                    nxt_r.tmo = 1'b1;
                end else begin
                    nxt_r.cnt = fpec_pkg::fpec_cnt_t'(r_ff.cnt - 1'b1);
                end
            end
            default: begin
                nxt_r.st = fpec_pkg::ST_IDLE;
            end
        endcase

        // Command register: starts only from idle, mass over page over row
        if (wr_fire && r_ff.awaddr == fpec_pkg::CMD_ADDR && r_ff.wstrb[0])
        begin
            if (r_ff.st == fpec_pkg::ST_IDLE) begin
                nxt_r.page = page_select;
                nxt_r.info = info_area_select;
                if (cmd[fpec_pkg::MASS_BIT]) begin
                    nxt_r.st = fpec_pkg::ST_MASS;
                    nxt_r.cnt =
                        fpec_pkg::fpec_cnt_t'(MASS_CYCLES - 1);
                end else if (cmd[fpec_pkg::PAGE_BIT]) begin
                    nxt_r.st = fpec_pkg::ST_PAGE;
                    nxt_r.cnt =
                        fpec_pkg::fpec_cnt_t'(PAGE_CYCLES - 1);
                end else if (cmd[fpec_pkg::ROW_BIT]) begin
                    nxt_r.st = fpec_pkg::ST_ROW;
                    nxt_r.col = {1'b0, col_start};
                    nxt_r.cnt =
                        fpec_pkg::fpec_cnt_t'(ROW_TMO_CYCLES - 1);
                end
            end else if (r_ff.st == fpec_pkg::ST_ROW &&
                         !cmd[fpec_pkg::ROW_BIT]) begin
                nxt_r.st = fpec_pkg::ST_IDLE;
            end
        end

        nxt_r.mass_on = nxt_r.st == fpec_pkg::ST_MASS;
        nxt_r.page_on = nxt_r.st == fpec_pkg::ST_PAGE;
        nxt_r.row_on = nxt_r.st == fpec_pkg::ST_ROW;
        nxt_r.rd_hold = nxt_r.st != fpec_pkg::ST_IDLE;
        nxt_r.wr_hold = nxt_r.mass_on || nxt_r.page_on;

        // Read channel, one outstanding read
        if (r_ff.arready && arvalid) begin
            nxt_r.arready = 1'b0;
            nxt_r.rvalid = 1'b1;
            nxt_r.rresp = fpec_pkg::RESP_OKAY;
            nxt_r.rdata = 32'h0000_0000;
            if (araddr == fpec_pkg::CMD_ADDR) begin
                // Upper command bits always read zero
                nxt_r.rdata[fpec_pkg::MASS_BIT] = r_ff.mass_on;
                nxt_r.rdata[fpec_pkg::PAGE_BIT] = r_ff.page_on;
                nxt_r.rdata[fpec_pkg::ROW_BIT] = r_ff.row_on;
            end else if (araddr == fpec_pkg::STAT_ADDR) begin
                nxt_r.rdata[fpec_pkg::TMO_BIT] = r_ff.tmo;
                nxt_r.rdata[fpec_pkg::DONE_BIT] = r_ff.done;
                nxt_r.rdata[fpec_pkg::COL_LSB +: 8] = r_ff.col;
            end else begin
                nxt_r.rresp = fpec_pkg::RESP_SLVERR;
            end
        end
        if (r_ff.rvalid && rready) begin
            nxt_r.rvalid = 1'b0;
            nxt_r.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_ff <= fpec_pkg::REGS_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign awready = r_ff.awready;
    assign wready = r_ff.wready;
    assign bvalid = r_ff.bvalid;
    assign bresp = r_ff.bresp;
    assign arready = r_ff.arready;
    assign rvalid = r_ff.rvalid;
    assign rdata = r_ff.rdata;
    assign rresp = r_ff.rresp;
    assign mass_erase_on = r_ff.mass_on;
    assign page_wipe_on = r_ff.page_on;
    assign row_write_on = r_ff.row_on;
    assign erase_page = r_ff.page;
    assign erase_info = r_ff.info;
    assign row_col = r_ff.col[6:0];
    assign flash_rd_hold = r_ff.rd_hold;
    assign flash_wr_hold = r_ff.wr_hold;

    rsvd_zero_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(rvalid) && $past(araddr) == fpec_pkg::CMD_ADDR
        |-> rdata[31:3] == 29'h0000_0000)
        else $error("Reserved command bits not zero");

    row_start_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        r_ff.aw_got && r_ff.w_got && !bvalid &&
        r_ff.awaddr == fpec_pkg::CMD_ADDR && r_ff.wstrb[0] &&
        r_ff.wdata[2:0] == 3'h4 && r_ff.st == fpec_pkg::ST_IDLE
        |=> row_write_on ##0 flash_rd_hold && !flash_wr_hold)
        else $error("Row programming did not start");

    row_end_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        row_write_on && row_byte_wr && r_ff.col == 8'h7f
        |=> !row_write_on && r_ff.done)
        else $error("Row programming did not end at column 128");

    row_tmo_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        row_write_on && !row_byte_wr && r_ff.cnt == '0
        |=> !row_write_on && r_ff.tmo)
        else $error("Row timeout did not clear the enable");

    page_done_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        page_wipe_on && r_ff.cnt == '0 |=> !page_wipe_on && r_ff.done)
        else $error("Page erase did not self-clear");

    mass_len_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(mass_erase_on)
        |-> r_ff.cnt == fpec_pkg::fpec_cnt_t'(MASS_CYCLES - 1))
        else $error("Full erase timer loaded wrongly");

    page_len_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(page_wipe_on)
        |-> r_ff.cnt == fpec_pkg::fpec_cnt_t'(PAGE_CYCLES - 1))
        else $error("Page erase timer loaded wrongly");

    erase_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (mass_erase_on || page_wipe_on) |-> flash_rd_hold && flash_wr_hold)
        else $error("Flash access not held during erase");

    row_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        row_write_on |-> flash_rd_hold && !flash_wr_hold)
        else $error("Flash read not held during row programming");

    reset_clear_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn)
        |-> !mass_erase_on && !page_wipe_on && !row_write_on)
        else $error("Command bits not cleared by reset");

    mass_start_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        r_ff.aw_got && r_ff.w_got && !bvalid &&
        r_ff.awaddr == fpec_pkg::CMD_ADDR && r_ff.wstrb[0] &&
        r_ff.wdata[fpec_pkg::MASS_BIT] && r_ff.st == fpec_pkg::ST_IDLE
        |=> mass_erase_on && flash_wr_hold)
        else $error("Full erase did not start");

    mass_done_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        mass_erase_on && r_ff.cnt == '0 |=> !mass_erase_on && r_ff.done)
        else $error("Full erase did not self-clear");

    page_start_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        r_ff.aw_got && r_ff.w_got && !bvalid &&
        r_ff.awaddr == fpec_pkg::CMD_ADDR && r_ff.wstrb[0] &&
        r_ff.wdata[fpec_pkg::PAGE_BIT] && !r_ff.wdata[fpec_pkg::MASS_BIT] &&
        r_ff.st == fpec_pkg::ST_IDLE
        |=> page_wipe_on && flash_wr_hold)
        else $error("Page erase did not start");

    row_abort_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        r_ff.aw_got && r_ff.w_got && !bvalid &&
        r_ff.awaddr == fpec_pkg::CMD_ADDR && r_ff.wstrb[0] &&
        !r_ff.wdata[fpec_pkg::ROW_BIT] && row_write_on
        |=> !row_write_on && !flash_rd_hold)
        else $error("Row programming not stopped by clearing its bit");

    idle_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !mass_erase_on && !page_wipe_on && !row_write_on
        |-> !flash_rd_hold && !flash_wr_hold)
        else $error("Flash access held while idle");
endmodule : fpec_ctrl
`default_nettype wire

// [design/fpec_pkg.sv]
// Purpose: Shared constants and types for the flash program/erase control.
// Assumes: 20 MHz system clock, AXI4-Lite register access, 32-bit data.
// Notes:   Register byte address is four times the register index.
package fpec_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned MASS_ERASE_MS = 200;
    localparam int unsigned PAGE_ERASE_MS = 10;
    localparam int unsigned ROW_TMO_US = 5000;
    localparam int unsigned MASS_CYC =
        int'((longint'(MASS_ERASE_MS) * CLK_HZ) / 1000);
    localparam int unsigned PAGE_CYC =
        int'((longint'(PAGE_ERASE_MS) * CLK_HZ) / 1000);
    localparam int unsigned ROW_TMO_CYC =
        int'((longint'(ROW_TMO_US) * CLK_HZ) / 1_000_000);
    localparam int CNT_W = 22;
    typedef logic [CNT_W-1:0] fpec_cnt_t;

    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CMD_IDX = 12'h0ff;
    localparam logic [ADDR_W-1:0] STAT_IDX = 12'h100;
    localparam logic [ADDR_W-1:0] CMD_ADDR = 12'(CMD_IDX * 4);
    localparam logic [ADDR_W-1:0] STAT_ADDR = 12'(STAT_IDX * 4);

    localparam int MASS_BIT = 0;
    localparam int PAGE_BIT = 1;
    localparam int ROW_BIT = 2;
    localparam int TMO_BIT = 0;
    localparam int DONE_BIT = 1;
    localparam int COL_LSB = 8;
    localparam logic [7:0] COL_END = 8'h80;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_MASS = 4'h2,
        ST_PAGE = 4'h4,
        ST_ROW  = 4'h8
    } fpec_state_t;

    typedef struct packed {
        fpec_state_t st;
        fpec_cnt_t cnt;
        logic [7:0] col;
        logic [6:0] page;
        logic info;
        logic tmo;
        logic done;
        logic mass_on;
        logic page_on;
        logic row_on;
        logic rd_hold;
        logic wr_hold;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fpec_regs_t;

    localparam fpec_regs_t REGS_RST = '{
        st: ST_IDLE, cnt: '0, col: 8'h00, page: 7'h00, info: 1'b0,
        tmo: 1'b0, done: 1'b0, mass_on: 1'b0, page_on: 1'b0,
        row_on: 1'b0, rd_hold: 1'b0, wr_hold: 1'b0, awready: 1'b1,
        wready: 1'b1, aw_got: 1'b0, w_got: 1'b0, awaddr: 12'h000,
        wdata: 32'h0000_0000, wstrb: 4'h0, bvalid: 1'b0,
        bresp: RESP_OKAY, arready: 1'b1, rvalid: 1'b0,
        rdata: 32'h0000_0000, rresp: RESP_OKAY
    };
endpackage : fpec_pkg

// [tb/fpec_flash_model.sv]
// Purpose: Flash engine stand-in that strobes row bytes.
// Assumes: One byte every other clock while a row is programmed.
// Notes:   hold_off stalls the engine so a row can time out.
`timescale 1ns/1ps
`default_nettype none
module fpec_flash_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Engine control
    input wire logic row_write_on,
    input wire logic hold_off,
    // Byte strobe
    output logic row_byte_wr
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            row_byte_wr <= 1'b0;
        end else begin
            // Gap cycle keeps a strobe from landing after the row ends
            row_byte_wr <= row_write_on && !hold_off &&
                !row_byte_wr;
        end
    end
endmodule : fpec_flash_model
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench for the flash program/erase control.
// Assumes: Shortened erase and timeout counts.
// Notes:   Registers reached by a small AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int MC = 20;
    localparam int PC = 10;
    localparam int TC = 50;
    localparam logic [11:0] CA = fpec_pkg::CMD_ADDR;
    localparam logic [11:0] SA = fpec_pkg::STAT_ADDR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [6:0] page_select = 7'h00, col_start = 7'h00, erase_page, row_col;
    logic info_area_select = 1'b0, hold_off = 1'b0, row_byte_wr;
    logic mass_erase_on, page_wipe_on, row_write_on, erase_info;
    logic flash_rd_hold, flash_wr_hold;
    int bad_count = 0, n_checks = 0, mc = 0, pc = 0;

    fpec_ctrl #(.MASS_CYCLES(MC), .PAGE_CYCLES(PC), .ROW_TMO_CYCLES(TC)) DUT (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
        .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .rvalid, .rready, .rdata, .rresp, .page_select,
        .info_area_select, .col_start, .row_byte_wr, .mass_erase_on,
        .page_wipe_on, .row_write_on, .erase_page, .erase_info, .row_col,
        .flash_rd_hold, .flash_wr_hold);
    fpec_flash_model engine (.aclk, .aresetn, .row_write_on, .hold_off,
        .row_byte_wr);

    initial begin
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (mass_erase_on === 1'b1) mc++;
        if (page_wipe_on === 1'b1) pc++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hf);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && awready) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [11:0] a);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rdr
    task automatic t_mass;
        rdr(CA);
        chk(rd, 32'h0);
        mc = 0;
        wr(CA, 32'h0000_00ff);
        chk(flash_wr_hold, 1'b1);
        rdr(CA);
        chk(rd, 32'h1);
        repeat (MC + 5) @(posedge aclk);
        chk(mc, MC);
        chk(flash_wr_hold, 1'b0);
        rdr(CA);
        chk(rd, 32'h0);
    endtask : t_mass
    task automatic t_page;
        int n;
        n = 0;
        pc = 0;
        page_select <= 7'h55;
        info_area_select <= 1'b1;
        wr(CA, 32'h2);
        chk(erase_page, 7'h55);
        chk(erase_info, 1'b1);
        chk(flash_rd_hold, 1'b1);
        do begin
            rdr(CA);
            n++;
        end while (rd[1] !== 1'b0 && n < 20);
        chk(rd, 32'h0);
        chk(pc, PC);
    endtask : t_page
    task automatic t_row;
        // Clear sticky flags left by the erase scenarios
        wr(SA, 32'h3);
        col_start <= 7'h78;
        wr(CA, 32'h4);
        chk(row_write_on, 1'b1);
        chk(flash_rd_hold, 1'b1);
        chk(flash_wr_hold, 1'b0);
        rdr(CA);
        chk(rd, 32'h4);
        repeat (20) @(posedge aclk);
        rdr(SA);
        chk(rd, 32'h8002);
        rdr(CA);
        chk(rd, 32'h0);
        wr(SA, 32'h3);
        hold_off <= 1'b1;
        wr(CA, 32'h4);
        repeat (TC + 10) @(posedge aclk);
        rdr(SA);
        chk(rd, 32'h7801);
        rdr(CA);
        chk(rd, 32'h0);
        chk(row_col, 7'h78);
        // Abort a stalled row by clearing its enable bit
        wr(SA, 32'h3);
        wr(CA, 32'h4);
        chk(row_write_on, 1'b1);
        wr(CA, 32'h0);
        chk(row_write_on, 1'b0);
        rdr(SA);
        chk(rd, 32'h7800);
        hold_off <= 1'b0;
    endtask : t_row
    task automatic t_bad;
        rdr(12'h010);
        chk(resp, fpec_pkg::RESP_SLVERR);
        chk(rd, 32'h0);
        wr(12'h010, 32'h7);
        chk(resp, fpec_pkg::RESP_SLVERR);
        chk(mass_erase_on, 1'b0);
        wr(CA, 32'h1, 4'he);
        chk(resp, fpec_pkg::RESP_OKAY);
        chk(mass_erase_on, 1'b0);
    endtask : t_bad
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_mass;
        t_page;
        t_row;
        t_bad;
        final_report;
    end
    initial begin
        repeat (3000) @(posedge aclk);
        bad_count++;
        final_report;
    end
endmodule : testbench
`default_nettype wire
